// *** logic/rre_pkg.sv ***
// Package for the return and rotate execution block.
// Assumes a core that drives one opcode for each instruction cycle,
// with the cycle cut into four Q phases.
package rre_pkg;
    // ****************************************************************
    // Opcode patterns
    // ****************************************************************
    localparam logic [14:0] RET_PATTERN = 15'h0009;   // Upper 15 bits
    localparam logic [5:0] ROT_PATTERN = 6'h0d;       // Bits 15..10
    localparam int ROT_DEST_BIT = 9;                  // Destination bit
    localparam int ROT_ACC_BIT = 8;                   // Access bit
    localparam int RET_SHADOW_BIT = 0;                // Shadow flag bit
    localparam logic [7:0] IDX_LIMIT = 8'h5f;         // Indexed window top
    localparam logic [7:0] ACC_SPLIT = 8'h60;         // Access bank split
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;      // Upper access bank

    // ****************************************************************
    // Status register field positions and reset values
    // ****************************************************************
    localparam int ST_C = 0;                          // Carry
    localparam int ST_Z = 2;                          // Zero
    localparam int ST_N = 4;                          // Negative
    localparam logic [7:0] RST_BYTE = 8'h00;          // Byte reset value
    localparam logic [3:0] RST_BANK = 4'h0;           // Bank reset value
    localparam logic [20:0] RST_PC = 21'h000000;      // PC reset value

    // ****************************************************************
    // Sequencer states and phase timing
    // ****************************************************************
    typedef enum logic [1:0] {
        RRE_IDLE = 2'b00,     // Free for a new opcode
        RRE_REFILL = 2'b01    // Second, empty return cycle
    } rre_state_t;

    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
endpackage

// *** logic/rre_rotate_alu.sv ***
// Rotate-left-through-carry datapath with flag results.
// Purely combinational; the sequencer registers its outputs.
`timescale 1ns/1ps
`default_nettype none
module rre_rotate_alu
    import rre_pkg::*;
(
    // Operand in
    input wire logic [7:0] operand,
    input wire logic carryIn,
    // Result out
    output logic [7:0] result,
    output logic carryOut,
    output logic negOut,
    output logic zeroOut
);
    // ****************************************************************
    // Rotate and flags
    // ****************************************************************
    always_comb begin
        result = {operand[6:0], carryIn};
        carryOut = operand[7];
        negOut = result[7];
        zeroOut = (result == 8'h00);
    end
endmodule // rre_rotate_alu
`default_nettype wire

// *** logic/rre_exec.sv ***
// Execution logic for subroutine return and rotate left through carry.
// Assumes opcodes arrive with a valid strobe in Q1, data memory
// answers reads combinationally, and the stack pops on a strobe.
// The Q phase count comes from outside; this block only follows it.
// A return holds the next instruction cycle while the pipeline
// refills, so an opcode offered in that cycle is dropped.
// The PC latches have no write path here and keep their reset value.
// Unknown opcodes pass through as empty cycles with no effect.
// Registers reset synchronously while rst is high.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rre_exec
    import rre_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Instruction stream
    input wire logic [1:0] qPhase,
    input wire logic opValid,
    input wire logic [15:0] opcode,
    input wire logic extendedEn,
    // Return stack
    input wire logic [20:0] stackTopValue,
    output logic stackPop,
    // Shadow copies
    input wire logic [7:0] workingRegShadow,
    input wire logic [7:0] statusShadow,
    input wire logic [3:0] bankSelectShadow,
    // Indexing base for literal offset mode
    input wire logic [11:0] indexBase,
    // Data memory
    output logic [11:0] memAddr,
    output logic memRead,
    input wire logic [7:0] memRdata,
    output logic memWrite,
    output logic [7:0] memWdata,
    // Core state
    output logic [20:0] pcOut,
    output logic [7:0] workingRegOut,
    output logic [7:0] statusOut,
    output logic [3:0] bankSelectRegOut,
    output logic [7:0] pcUpperLatch,
    output logic [7:0] pcHighLatch,
    output logic busy
);
    // ****************************************************************
    // State
    // ****************************************************************
    // Each register but the PC latches has its next value beside it; only the
    // registers block below moves next values into them, and
    // only the next-state block decides what they will be.
    rre_state_t state_ff, nxt_state;          // Sequencer
    logic [20:0] pc_ff, nxt_pc;               // Program counter
    logic [7:0] wreg_ff, nxt_wreg;            // Working register
    logic [7:0] stat_ff, nxt_stat;            // Status register
    logic [3:0] bank_ff, nxt_bank;            // Bank select register
    logic [7:0] pclu_ff, pclh_ff;             // PC latches, held
    logic [15:0] op_ff, nxt_op;               // Opcode in flight
    logic isRet_ff, nxt_isRet;                // Return active
    logic isRot_ff, nxt_isRot;                // Rotate active
    logic [7:0] opnd_ff, nxt_opnd;            // Byte read in Q2
    logic [7:0] res_ff, nxt_res;              // Result from Q3
    logic cy_ff, nxt_cy;                      // Carry out from Q3
    logic ng_ff, nxt_ng;                      // Negative from Q3
    logic zr_ff, nxt_zr;                      // Zero from Q3
    logic [11:0] addr_ff, nxt_addr;           // Effective address

    // ALU wires
    // They settle from the Q2 operand and are taken at the Q3 edge
    logic [7:0] aluRes;
    logic aluCy, aluNg, aluZr;

    // ****************************************************************
    // Decode functions
    // ****************************************************************
    // Decoding is by fixed bit patterns; anything that matches
    // neither pattern leaves the block idle for that cycle.
    // Both decoders look at the opcode as offered in Q1.
    // Return opcode: fixed upper 15 bits
    function automatic logic isReturn(input logic [15:0] op);
        return op[15:1] == RET_PATTERN;
    endfunction

    // Rotate opcode: fixed upper six bits
    function automatic logic isRotate(input logic [15:0] op);
        return op[15:10] == ROT_PATTERN;
    endfunction

    // Effective file address
    function automatic logic [11:0] effAddr(input logic [15:0] op,
                                            input logic [3:0] bank_select_reg,
                                            input logic ext,
                                            input logic [11:0] base);
        logic [7:0] f;
        f = op[7:0];
        if (op[ROT_ACC_BIT]) begin
            // Banked: bank select gives the upper four bits
            effAddr = {bank_select_reg, f};
        end else if (ext && (f <= IDX_LIMIT)) begin
            // Indexed: literal offset from the index base
            effAddr = base + {4'h0, f};
        end else if (f < ACC_SPLIT) begin
            // Access bank, lower part sits in bank zero
            effAddr = {RST_BANK, f};
        end else begin
            // Access bank, upper part maps to the top bank
            effAddr = {ACC_HIGH_BANK, f};
        end
    endfunction

    // ****************************************************************
    // Rotate datapath
    // ****************************************************************
    // The datapath sees the Q2 operand and the carry as it stands;
    // its outputs are only registered at the Q3 edge, so the carry
    // written in Q4 cannot reach the result of the same rotate.
    // The next rotate then starts from the carry just written.
    rre_rotate_alu u_alu (
        .operand(opnd_ff),
        .carryIn(stat_ff[ST_C]),
        .result(aluRes),
        .carryOut(aluCy),
        .negOut(aluNg),
        .zeroOut(aluZr)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    // One pass per clock; each Q phase does its own share of work.
    // Strobes default low so that each lasts exactly one clock.
    // Every register keeps its value unless a phase below sets it.
    always_comb begin
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_wreg = wreg_ff;
        nxt_stat = stat_ff;
        nxt_bank = bank_ff;
        nxt_op = op_ff;
        nxt_isRet = isRet_ff;
        nxt_isRot = isRot_ff;
        nxt_opnd = opnd_ff;
        nxt_res = res_ff;
        nxt_cy = cy_ff;
        nxt_ng = ng_ff;
        nxt_zr = zr_ff;
        nxt_addr = addr_ff;
        stackPop = 1'b0;
        memRead = 1'b0;
        memWrite = 1'b0;
        case (qPhase)
            Q1: begin
                // Decode in Q1 of a fresh cycle
                if (state_ff == RRE_REFILL) begin
                    // Refill cycle: the offered opcode is dropped
                    nxt_isRet = 1'b0;
                    nxt_isRot = 1'b0;
                end else if (opValid) begin
                    // Fresh opcode: latch it and work out the address
                    nxt_op = opcode;
                    nxt_isRet = isReturn(opcode);
                    nxt_isRot = isRotate(opcode);
                    nxt_addr = effAddr(opcode, bank_ff, extendedEn,
                                       indexBase);
                end else begin
                    // No opcode: an empty cycle
                    nxt_isRet = 1'b0;
                    nxt_isRot = 1'b0;
                end
            end
            Q2: begin
                // Rotate reads its operand
                if (isRot_ff) begin
                    // Latch the byte that memory answers
                    memRead = 1'b1;
                    nxt_opnd = memRdata;
                end
            end
            Q3: begin
                // Rotate computes
                if (isRot_ff) begin
                    // Hold result and flags until Q4
                    nxt_res = aluRes;
                    nxt_cy = aluCy;
                    nxt_ng = aluNg;
                    nxt_zr = aluZr;
                end
            end
            Q4: begin
                // Results land at the end of the cycle
                if (state_ff == RRE_REFILL) begin
                    // End of the empty second cycle of a return
                    nxt_state = RRE_IDLE;
                end else if (isRet_ff) begin
                    // Pop stack; latches left alone, flags restored from the shadow only when the shadow bit is set
                    stackPop = 1'b1;
                    nxt_pc = stackTopValue;
                    nxt_state = RRE_REFILL;
                    if (op_ff[RET_SHADOW_BIT]) begin
                        nxt_wreg = workingRegShadow;
                        nxt_stat = statusShadow;
                        nxt_bank = bankSelectShadow;
                    end
                end else if (isRot_ff) begin
                    // Rotate: flags, then the chosen destination
                    nxt_stat[ST_C] = cy_ff;
                    nxt_stat[ST_N] = ng_ff;
                    nxt_stat[ST_Z] = zr_ff;
                    if (op_ff[ROT_DEST_BIT]) begin
                        // Result back to the file register
                        memWrite = 1'b1;
                    end else begin
                        // Result to the working register
                        nxt_wreg = res_ff;
                    end
                end
            end
            default: begin
                // Unreachable with a two-bit phase; hold everything
                nxt_state = state_ff;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Plain registers with a synchronous reset; no logic lives here
    // beyond the reset values, so the next-state block owns it all.
    // The strobes are decoded and so need no reset of their own.
    always_ff @(posedge clock) begin
        if (rst) begin
            // Everything to its reset value
            state_ff <= RRE_IDLE;
            pc_ff <= RST_PC;
            wreg_ff <= RST_BYTE;
            stat_ff <= RST_BYTE;
            bank_ff <= RST_BANK;
            pclu_ff <= RST_BYTE;
            pclh_ff <= RST_BYTE;
            op_ff <= 16'h0000;
            isRet_ff <= 1'b0;
            isRot_ff <= 1'b0;
            opnd_ff <= RST_BYTE;
            res_ff <= RST_BYTE;
            cy_ff <= 1'b0;
            ng_ff <= 1'b0;
            zr_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else begin
            // Take the next values; the PC latches only hold
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            wreg_ff <= nxt_wreg;
            stat_ff <= nxt_stat;
            bank_ff <= nxt_bank;
            pclu_ff <= pclu_ff;
            pclh_ff <= pclh_ff;
            op_ff <= nxt_op;
            isRet_ff <= nxt_isRet;
            isRot_ff <= nxt_isRot;
            opnd_ff <= nxt_opnd;
            res_ff <= nxt_res;
            cy_ff <= nxt_cy;
            ng_ff <= nxt_ng;
            zr_ff <= nxt_zr;
            addr_ff <= nxt_addr;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Data outputs come straight from registers; only the strobes
    // and busy are decoded, and those from registered state and
    // the Q phase alone, so no input but qPhase reaches an output in one path.
    assign memAddr = addr_ff;
    assign memWdata = res_ff;
    assign pcOut = pc_ff;
    assign workingRegOut = wreg_ff;
    assign statusOut = stat_ff;
    assign bankSelectRegOut = bank_ff;
    assign pcUpperLatch = pclu_ff;
    assign pcHighLatch = pclh_ff;
    // Busy is high from the edge that takes an opcode until the end of the refill cycle for a return, or the following Q1 edge for a rotate
    assign busy = (state_ff == RRE_REFILL) | isRet_ff | isRot_ff;
endmodule // rre_exec
`default_nettype wire

// *** testbench/rre_exec_props.sv ***
// Checker for the return and rotate execution block.
// Assumes it is bound onto rre_exec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rre_exec_props
    import rre_pkg::*;
(
    // Clock, reset and instruction stream
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] qPhase,
    input wire logic opValid,
    input wire logic [15:0] opcode,
    // Return stack and shadow
    input wire logic [20:0] stackTopValue,
    input wire logic stackPop,
    input wire logic [7:0] workingRegShadow,
    // Data memory
    input wire logic memRead,
    input wire logic [7:0] memRdata,
    input wire logic memWrite,
    input wire logic [7:0] memWdata,
    // Core state
    input wire logic [20:0] pcOut,
    input wire logic [7:0] workingRegOut,
    input wire logic [7:0] statusOut,
    input wire logic [7:0] pcUpperLatch,
    input wire logic [7:0] pcHighLatch
);
    // ****************************************************************
    // Properties, all on the one clock
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pop_in_q4: assert property (stackPop |-> qPhase == Q4)
        else $error("stack pop outside Q4");
    a_pc_from_stack: assert property (stackPop |=>
        pcOut == $past(stackTopValue)) else $error("pc not loaded");
    a_latches_held: assert property (pcUpperLatch == 8'h00
        && pcHighLatch == 8'h00) else $error("pc latch changed");
    a_read_in_q2: assert property (memRead |-> qPhase == Q2)
        else $error("read outside Q2");
    a_write_in_q4: assert property (memWrite |-> qPhase == Q4
        && !stackPop) else $error("write outside Q4");
    a_rotate_bits: assert property (memRead |-> ##2
        memWdata[7:1] == $past(memRdata[6:0], 2))
        else $error("rotate result wrong");
    a_flags_follow: assert property (memWrite |=>
        statusOut[ST_N] == $past(memWdata[7])
        && statusOut[ST_Z] == ($past(memWdata) == 8'h00))
        else $error("flags wrong");
    a_no_shadow: assert property ((qPhase == Q1 && opValid
        && opcode == 16'h0012) |-> ##4
        workingRegOut == $past(workingRegOut, 4)) else $error("W changed");
    a_shadow_load: assert property ((qPhase == Q1 && opValid
        && opcode == 16'h0013) |-> ##4
        workingRegOut == $past(workingRegShadow)) else $error("no restore");

    // Main scenarios reached
    c_pop: cover property (stackPop);
    c_write: cover property (memWrite);
    c_read_no_write: cover property (memRead ##2 !memWrite);
endmodule // rre_exec_props
`default_nettype wire

// *** testbench/rre_exec_tb.sv ***
// Self-checking bench for the return and rotate execution block.
// Assumes the bench supplies the Q phase and answers memory reads.
`timescale 1ns/1ps
`default_nettype none
module rre_exec_tb;
    import rre_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clock = 1'b0, rst = 1'b1, opValid = 1'b0, extendedEn = 1'b0;
    logic [1:0] qPhase = Q1;
    logic [15:0] opcode = 16'h0000;
    logic [20:0] stackTopValue = 21'h000000, pcOut, expPc;
    logic [7:0] workingRegShadow = 8'h00, statusShadow = 8'h00;
    logic [3:0] bankSelectShadow = 4'h0, bankSelectRegOut, expBank;
    logic [11:0] indexBase = 12'h200, memAddr, sawAddr;
    logic [7:0] memRdata = 8'h00, memWdata, workingRegOut, statusOut;
    logic [7:0] pcUpperLatch, pcHighLatch, expW, expSt, sawWd, res;
    logic stackPop, memRead, memWrite, busy, sawRd, sawWr, sawPop;
    int mismatches = 0, check_count = 0;

    rre_exec uut (.clock(clock), .rst(rst), .qPhase(qPhase),
        .opValid(opValid), .opcode(opcode), .extendedEn(extendedEn),
        .stackTopValue(stackTopValue), .stackPop(stackPop),
        .workingRegShadow(workingRegShadow), .statusShadow(statusShadow),
        .bankSelectShadow(bankSelectShadow), .indexBase(indexBase),
        .memAddr(memAddr), .memRead(memRead), .memRdata(memRdata),
        .memWrite(memWrite), .memWdata(memWdata), .pcOut(pcOut),
        .workingRegOut(workingRegOut), .statusOut(statusOut),
        .bankSelectRegOut(bankSelectRegOut), .pcUpperLatch(pcUpperLatch),
        .pcHighLatch(pcHighLatch), .busy(busy));

    // 200 MHz clock; Q phase steps once a clock from Q1 after reset
    always #2.5 clock = ~clock;
    always @(posedge clock) qPhase <= rst ? Q1 : qPhase + 2'h1;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One instruction cycle; nxt is offered in the following Q1
    task automatic exec(input logic [15:0] op, input logic [15:0] nxt);
        int n;
        n = 0;
        @(posedge clock);
        while (qPhase !== Q4 && n < 8) begin
            @(posedge clock);
            n++;
        end
        opcode <= op;
        opValid <= 1'b1;
        @(posedge clock);
        opValid <= 1'b0;
        @(negedge clock);
        sawRd = memRead;
        sawAddr = memAddr;
        repeat (2) @(negedge clock);
        sawWr = memWrite;
        sawWd = memWdata;
        sawPop = stackPop;
        @(posedge clock);
        opcode <= nxt;
        opValid <= (nxt != 16'h0000);
        @(negedge clock);
    endtask

    // Full visible core state against the expected copy
    task automatic chk_state();
        chk(pcOut, expPc);
        chk(workingRegOut, expW);
        chk(statusOut, expSt);
        chk(bankSelectRegOut, expBank);
        chk({pcUpperLatch, pcHighLatch}, 16'h0000);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Return; a rotate offered in the refill cycle must be ignored
    task automatic ret(input logic s, input logic [20:0] stack_top_value,
                       input logic [7:0] w, input logic [7:0] st);
        @(posedge clock);
        stackTopValue <= stack_top_value;
        workingRegShadow <= w;
        statusShadow <= st;
        bankSelectShadow <= 4'h3;
        exec({15'h0009, s}, 16'h3510);
        chk(sawPop, 1'b1);
        chk(sawRd, 1'b0);
        expPc = stack_top_value;
        if (s) begin
            expW = w;
            expSt = st;
            expBank = 4'h3;
        end
        chk_state();
        @(posedge clock);
        opValid <= 1'b0;
        @(negedge clock);
        chk(busy, 1'b1);
        chk(memRead, 1'b0);
    endtask

    // Rotate f through carry, expecting address ea
    task automatic rot(input logic d, input logic a, input logic [7:0] f,
                       input logic [7:0] rd, input logic [11:0] ea);
        @(posedge clock);
        memRdata <= rd;
        exec({ROT_PATTERN, d, a, f}, 16'h0000);
        res = {rd[6:0], expSt[ST_C]};
        expSt[ST_C] = rd[7];
        expSt[ST_N] = res[7];
        expSt[ST_Z] = (res == 8'h00);
        if (!d) expW = res;
        chk(sawRd, 1'b1);
        chk(sawPop, 1'b0);
        chk(sawAddr, ea);
        chk(sawWr, d);
        if (d) chk(sawWd, res);
        chk_state();
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        {expPc, expW, expSt, expBank} = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk_state();
        chk(busy, 1'b0);
        ret(1'b1, 21'h1abcd, 8'h5a, 8'he1);
        rot(1'b1, 1'b1, 8'h12, 8'hc3, 12'h312);
        rot(1'b0, 1'b0, 8'h70, 8'h40, 12'hf70);
        rot(1'b1, 1'b0, 8'h5f, 8'h80, 12'h05f);
        @(posedge clock);
        extendedEn <= 1'b1;
        rot(1'b1, 1'b0, 8'h5f, 8'h01, 12'h25f);
        rot(1'b0, 1'b0, 8'h60, 8'h00, 12'hf60);
        rot(1'b1, 1'b1, 8'h05, 8'hff, 12'h305);
        ret(1'b0, 21'h00123, 8'h11, 8'h00);
        results();
    end

    initial begin
        #50000;
        mismatches++;
        results();
    end
endmodule // rre_exec_tb

bind rre_exec rre_exec_props u_props (.clock(clock), .rst(rst),
    .qPhase(qPhase), .opValid(opValid), .opcode(opcode),
    .stackTopValue(stackTopValue), .stackPop(stackPop),
    .workingRegShadow(workingRegShadow), .memRead(memRead),
    .memRdata(memRdata), .memWrite(memWrite), .memWdata(memWdata),
    .pcOut(pcOut), .workingRegOut(workingRegOut), .statusOut(statusOut),
    .pcUpperLatch(pcUpperLatch), .pcHighLatch(pcHighLatch));
`default_nettype wire
